// file: rtl/cair_id_meter.sv
// Timed ID-resistor conversion: waits the conversion time, then captures the code.
module cair_id_meter #(
  parameter int CYCLES = cair_pkg::CONV_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [2:0] codeIn,
  output logic            busy,
  output logic            finish,
  output logic [2:0]      code
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_ff;

  // The go bit is still high in the cycle that reports completion.
  // Without the finish guard it would launch a second, unrequested run.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy     <= 1'b0;
      count_ff <= '0;
    end else if (start && !busy && !finish) begin
      busy     <= 1'b1;
      count_ff <= '0;
    end else if (busy && count_ff == LAST) begin
      busy     <= 1'b0;
    end else if (busy) begin
      count_ff <= count_ff + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      finish <= 1'b0;
      code   <= cair_pkg::CODE_RESET;
    end else begin
      finish <= busy && count_ff == LAST;
      if (busy && count_ff == LAST) begin
        code <= codeIn;
      end
    end
  end
endmodule : cair_id_meter

// file: rtl/cair_line_route.sv
// Charger detection line routing with optional DP/DM reversal and comparator gating.
module cair_line_route (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] chgCtrl,
  input  wire logic       dpVoltRaw,
  input  wire logic       dmVoltRaw,
  input  wire logic [1:0] lineState,
  output logic            srcDpOn,
  output logic            srcDmOn,
  output logic            sinkDpOn,
  output logic            sinkDmOn,
  output logic            probeDpOn,
  output logic            probeDmOn,
  output logic            lineVoltSeen
);
  logic role;
  logic sensed;

  assign role   = chgCtrl[cair_pkg::BIT_ROLE];
  assign sensed = role ? dmVoltRaw : dpVoltRaw;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      srcDpOn   <= 1'b0;
      srcDmOn   <= 1'b0;
      sinkDpOn  <= 1'b0;
      sinkDmOn  <= 1'b0;
      probeDpOn <= 1'b0;
      probeDmOn <= 1'b0;
    end else begin
      srcDpOn   <= chgCtrl[cair_pkg::BIT_SRC] & ~role;
      srcDmOn   <= chgCtrl[cair_pkg::BIT_SRC] & role;
      sinkDpOn  <= chgCtrl[cair_pkg::BIT_SINK] & ~role;
      sinkDmOn  <= chgCtrl[cair_pkg::BIT_SINK] & role;
      probeDpOn <= chgCtrl[cair_pkg::BIT_PROBE] & ~role;
      probeDmOn <= chgCtrl[cair_pkg::BIT_PROBE] & role;
    end
  end

  // The comparator is only trusted while the sink is on and the bus idles in SE0.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineVoltSeen <= 1'b0;
    end else begin
      lineVoltSeen <= sensed & chgCtrl[cair_pkg::BIT_SINK]
                    & (lineState == cair_pkg::LINE_SE0);
    end
  end
endmodule : cair_line_route

// file: rtl/cair_pkg.sv
// Shared constants for the charger, audio key and ID-resistor register bank.
// Notes on behaviour
// - Charger-detection control and status register sits at 32h, read and write.
// - Bit 0 enables the data-line voltage source, bit 2 the contact probe.
// - Read-only bit 4 shows the comparator; only reports with sink enabled.
// - Voltage seen reads 1 only with voltage on DP (DM when bit 3 is set) and line state 00b.
// - Headset audio key register at 33h: bits 3:0 read/write, 7:4 read zero.
// - Headset audio mode is on only while the key field holds 1010.
// - ID conversion register reads at 36h-38h; write loads, set ORs, clear clears.
// - Bits 2:0 hold the measured ID resistance code.
// - Conversion-done bit 3 asserts by itself after a 282 us conversion.
// - Done flag clears itself when the ID register is read.
// - Reading the value through carkit status leaves done flags unchanged.
// - Bit 4 starts a measurement when written or set; clears at completion.
// - With bit 6 set, alt_int is raised when the done flag asserts.
// - Bit 6 is ORed with the carkit status interrupt enable.
// - Vendor registers 30h-3Fh are reached by immediate register reads and writes.
// - Carkit conversion latch sets on enabled done rise, clears when read.
package cair_pkg;
  localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
  localparam logic [5:0] ADDR_CHG       = 6'h32;
  localparam logic [5:0] ADDR_AUDIO     = 6'h33;
  localparam logic [5:0] ADDR_ID_WR     = 6'h36;
  localparam logic [5:0] ADDR_ID_SET    = 6'h37;
  localparam logic [5:0] ADDR_ID_CLR    = 6'h38;

  localparam int BIT_SRC    = 0;
  localparam int BIT_SINK   = 1;
  localparam int BIT_PROBE  = 2;
  localparam int BIT_ROLE   = 3;
  localparam int BIT_SEEN   = 4;
  localparam int BIT_DONE   = 3;
  localparam int BIT_GO     = 4;
  localparam int BIT_RSV5   = 5;
  localparam int BIT_IRQ    = 6;

  localparam logic [3:0] CHG_RESET   = 4'h0;
  localparam logic [3:0] AUDIO_RESET = 4'h0;
  localparam logic [3:0] AUDIO_KEY   = 4'hA;
  localparam logic [2:0] CODE_RESET  = 3'h0;
  // Writable bits of the ID conversion register: code, go, reserved bit 5, irq enable.
  localparam logic [7:0] ID_WR_MASK  = 8'h77;

  localparam logic [1:0] LINE_SE0 = 2'h0;

  localparam int CLK_HZ       = 10_000_000;
  localparam int CONV_TIME_US = 282;
  localparam int CONV_CYCLES  = (CONV_TIME_US * (CLK_HZ / 1_000_000));
endpackage : cair_pkg

// file: rtl/cair_regs.sv
// Vendor register bank: charger detection, headset audio key, ID-resistor conversion.
module cair_regs #(
  parameter int CONV_CYCLES = cair_pkg::CONV_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic [7:0]      regRdData,
  output logic            regRdValid,
  input  wire logic [1:0] lineState,
  input  wire logic       dpVoltRaw,
  input  wire logic       dmVoltRaw,
  input  wire logic [2:0] idCodeIn,
  input  wire logic       carkitIrqEn,
  input  wire logic       carkitLatchRead,
  output logic            srcDpOn,
  output logic            srcDmOn,
  output logic            sinkDpOn,
  output logic            sinkDmOn,
  output logic            probeDpOn,
  output logic            probeDmOn,
  output logic            lineVoltSeen,
  output logic            headsetAudioOn,
  output logic            idMeasureBusy,
  output logic            idMeasureFinished,
  output logic [2:0]      idResistanceCode,
  output logic            altInt,
  output logic            idConvLatch
);
  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [3:0] chgCtrl_ff;
  logic [3:0] headsetKeyField_ff;
  logic [2:0] idCode_ff;
  logic       idDone_ff;
  logic       idGo_ff;
  logic       idRsv5_ff;
  logic       idIrqOn_ff;
  logic       meterBusy;
  logic       meterFinish;
  logic [2:0] meterCode;
  logic       seen;
  logic [7:0] idImage;
  logic [7:0] nxt_idBits;
  logic       wrLoad;
  logic       wrSet;
  logic       wrClr;
  logic       idRead;

  function automatic logic [7:0] id_image(input logic [2:0] c, input logic d, input logic g,
                                          input logic r, input logic e);
    id_image = {1'b0, e, r, g, d, c};
  endfunction : id_image

  assign wrLoad  = regWrEn && regAddr == cair_pkg::ADDR_ID_WR;
  assign wrSet   = regWrEn && regAddr == cair_pkg::ADDR_ID_SET;
  assign wrClr   = regWrEn && regAddr == cair_pkg::ADDR_ID_CLR;
  assign idRead  = regRdEn && regAddr >= cair_pkg::ADDR_ID_WR
                           && regAddr <= cair_pkg::ADDR_ID_CLR;
  assign idImage = id_image(idCode_ff, idDone_ff, idGo_ff, idRsv5_ff, idIrqOn_ff);

  // ------------------------------------------------------------------
  // Charger detection and audio key
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chgCtrl_ff <= cair_pkg::CHG_RESET;
    end else if (regWrEn && regAddr == cair_pkg::ADDR_CHG) begin
      chgCtrl_ff <= regWrData[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      headsetKeyField_ff <= cair_pkg::AUDIO_RESET;
      headsetAudioOn     <= 1'b0;
    end else begin
      if (regWrEn && regAddr == cair_pkg::ADDR_AUDIO) begin
        headsetKeyField_ff <= regWrData[3:0];
      end
      headsetAudioOn <= headsetKeyField_ff == cair_pkg::AUDIO_KEY;
    end
  end

  cair_line_route u_route (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .chgCtrl      (chgCtrl_ff),
    .dpVoltRaw    (dpVoltRaw),
    .dmVoltRaw    (dmVoltRaw),
    .lineState    (lineState),
    .srcDpOn      (srcDpOn),
    .srcDmOn      (srcDmOn),
    .sinkDpOn     (sinkDpOn),
    .sinkDmOn     (sinkDmOn),
    .probeDpOn    (probeDpOn),
    .probeDmOn    (probeDmOn),
    .lineVoltSeen (seen)
  );
  assign lineVoltSeen = seen;

  // ------------------------------------------------------------------
  // ID-resistor conversion register
  // ------------------------------------------------------------------
  always_comb begin
    nxt_idBits = idImage;
    if (wrLoad) begin
      nxt_idBits = regWrData & cair_pkg::ID_WR_MASK;
    end else if (wrSet) begin
      nxt_idBits = idImage | (regWrData & cair_pkg::ID_WR_MASK);
    end else if (wrClr) begin
      nxt_idBits = idImage & ~(regWrData & cair_pkg::ID_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idCode_ff  <= cair_pkg::CODE_RESET;
      idGo_ff    <= 1'b0;
      idRsv5_ff  <= 1'b0;
      idIrqOn_ff <= 1'b0;
    end else begin
      idRsv5_ff  <= nxt_idBits[cair_pkg::BIT_RSV5];
      idIrqOn_ff <= nxt_idBits[cair_pkg::BIT_IRQ];
      // Completion outranks a software write to the code and the go bit.
      if (meterFinish) begin
        idCode_ff <= meterCode;
        idGo_ff   <= 1'b0;
      end else begin
        idCode_ff <= nxt_idBits[2:0];
        idGo_ff   <= nxt_idBits[cair_pkg::BIT_GO];
      end
    end
  end

  // A done event in the cycle of a read wins, so a finished conversion is never lost.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idDone_ff <= 1'b0;
    end else if (meterFinish) begin
      idDone_ff <= 1'b1;
    end else if (idRead) begin
      idDone_ff <= 1'b0;
    end
  end

  cair_id_meter #(
    .CYCLES (CONV_CYCLES)
  ) u_meter (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (idGo_ff),
    .codeIn  (idCodeIn),
    .busy    (meterBusy),
    .finish  (meterFinish),
    .code    (meterCode)
  );

  // ------------------------------------------------------------------
  // Interrupt indication and carkit latch
  // ------------------------------------------------------------------
  logic irqOn;
  assign irqOn = idIrqOn_ff | carkitIrqEn;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      altInt      <= 1'b0;
      idConvLatch <= 1'b0;
    end else begin
      altInt <= meterFinish && !idDone_ff && irqOn;
      if (meterFinish && !idDone_ff && irqOn) begin
        idConvLatch <= 1'b1;
      end else if (carkitLatchRead) begin
        idConvLatch <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idMeasureBusy     <= 1'b0;
      idMeasureFinished <= 1'b0;
      idResistanceCode  <= cair_pkg::CODE_RESET;
    end else begin
      idMeasureBusy     <= meterBusy;
      idMeasureFinished <= idDone_ff;
      idResistanceCode  <= idCode_ff;
    end
  end

  // ------------------------------------------------------------------
  // Immediate register read port
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        if (regAddr == cair_pkg::ADDR_CHG) begin
          regRdData <= {3'h0, seen, chgCtrl_ff};
        end else if (regAddr == cair_pkg::ADDR_AUDIO) begin
          regRdData <= {4'h0, headsetKeyField_ff};
        end else if (idRead) begin
          regRdData <= idImage;
        end else begin
          regRdData <= 8'h00;
        end
      end
    end
  end
endmodule : cair_regs

// file: verification/cair_link_model.sv
// Link-side model issuing immediate register reads and writes.
module cair_link_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid,
  output logic [5:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrEn,
  output logic            regRdEn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regAddr = 6'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // Released lines show the inverse so a stale value is never mistaken for live data.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= (a inside {[6'h36:6'h38]}) ? (d & 8'hDF) : d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
    regAddr <= ~a;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    v = regRdValid;
    d = regRdData;
  endtask : rd
endmodule : cair_link_model

// file: verification/cair_regs_properties.sv
// Concurrent checks on the ports of the cair_regs register bank.
module cair_regs_properties #(
  parameter int CONV_CYCLES = cair_pkg::CONV_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic [1:0] lineState,
  input wire logic       carkitLatchRead,
  input wire logic       srcDpOn,
  input wire logic       srcDmOn,
  input wire logic       sinkDpOn,
  input wire logic       sinkDmOn,
  input wire logic       lineVoltSeen,
  input wire logic       headsetAudioOn,
  input wire logic       idMeasureBusy,
  input wire logic       idMeasureFinished,
  input wire logic       altInt,
  input wire logic       idConvLatch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----
  // Conversion length counter and port assertions
  // ----
  logic [15:0] busyCnt_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      busyCnt_ff <= 16'h0000;
    else
      busyCnt_ff <= idMeasureBusy ? busyCnt_ff + 16'h0001 : 16'h0000;
  end
  property p_key;
    logic [3:0] k;
    (regWrEn && regAddr == 6'h33, k = regWrData[3:0]) |-> ##2 (headsetAudioOn == (k == 4'hA));
  endproperty
  a_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  a_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("valid without read");
  a_unmapped_zero: assert property (regRdEn
    && !(regAddr inside {6'h32, 6'h33, [6'h36:6'h38]}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_audio_upper: assert property (regRdEn && regAddr == 6'h33 |=> regRdData[7:4] == 4'h0)
    else $error("audio upper bits set");
  a_audio_key: assert property (p_key) else $error("audio mode wrong");
  a_id_bit7: assert property (regRdEn && regAddr inside {[6'h36:6'h38]} |=> !regRdData[7])
    else $error("id bit 7 set");
  a_seen_gate: assert property (lineVoltSeen |-> (sinkDpOn || sinkDmOn)
    && $past(lineState) == 2'h0) else $error("voltage seen ungated");
  a_role_excl: assert property (!(srcDpOn && srcDmOn) && !(sinkDpOn && sinkDmOn))
    else $error("both lines driven");
  a_done_clear: assert property (regRdEn && regAddr inside {[6'h36:6'h38]}
    && idMeasureFinished && !idMeasureBusy |-> ##2 !idMeasureFinished)
    else $error("done not cleared");
  a_irq_pulse: assert property (altInt |=> idMeasureFinished && !altInt)
    else $error("alt interrupt wrong");
  a_latch_hold: assert property (idConvLatch && !carkitLatchRead |=> idConvLatch)
    else $error("latch lost");
  a_conv_length: assert property ($fell(idMeasureBusy)
    |-> busyCnt_ff >= CONV_CYCLES - 2 && busyCnt_ff <= CONV_CYCLES + 2)
    else $error("conversion length wrong");
  c_irq: cover property (altInt);
  c_audio: cover property (headsetAudioOn);
  c_seen: cover property (lineVoltSeen);
endmodule : cair_regs_properties

bind cair_regs cair_regs_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
  .lineState(lineState), .carkitLatchRead(carkitLatchRead), .srcDpOn(srcDpOn),
  .srcDmOn(srcDmOn), .sinkDpOn(sinkDpOn), .sinkDmOn(sinkDmOn), .lineVoltSeen(lineVoltSeen),
  .headsetAudioOn(headsetAudioOn), .idMeasureBusy(idMeasureBusy),
  .idMeasureFinished(idMeasureFinished), .altInt(altInt), .idConvLatch(idConvLatch));

// file: verification/testbench.sv
// Self-checking bench for the cair_regs register bank.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] r; logic k;} cair_row_t;
  logic ref_clk = 1'b0, nrst = 1'b0, regWrEn, regRdEn, regRdValid, dpVoltRaw = 1'b0;
  logic dmVoltRaw = 1'b0, carkitIrqEn = 1'b0, carkitLatchRead = 1'b0, srcDpOn, srcDmOn;
  logic sinkDpOn, sinkDmOn, probeDpOn, probeDmOn, lineVoltSeen, headsetAudioOn, v;
  logic idMeasureBusy, idMeasureFinished, altInt, idConvLatch;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, d;
  logic [1:0] lineState = 2'h0;
  logic [2:0] idCodeIn = 3'h0, idResistanceCode;
  int n_mismatch = 0, comparisons = 0;
  cair_row_t rows[10] = '{'{6'h32, 8'hFF, 8'h0F, 1'b0}, '{6'h32, 8'h00, 8'h00, 1'b0},
    '{6'h33, 8'hFF, 8'h0F, 1'b0}, '{6'h33, 8'h0A, 8'h0A, 1'b1}, '{6'h33, 8'h0B, 8'h0B, 1'b0},
    '{6'h3F, 8'hAA, 8'h00, 1'b0}, '{6'h36, 8'hEF, 8'h47, 1'b0}, '{6'h37, 8'h08, 8'h47, 1'b0},
    '{6'h38, 8'h43, 8'h04, 1'b0}, '{6'h38, 8'h04, 8'h00, 1'b0}};
  always #50 ref_clk = ~ref_clk;
  cair_regs #(.CONV_CYCLES(20)) DUT (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .lineState(lineState), .dpVoltRaw(dpVoltRaw),
    .dmVoltRaw(dmVoltRaw), .idCodeIn(idCodeIn), .carkitIrqEn(carkitIrqEn),
    .carkitLatchRead(carkitLatchRead), .srcDpOn(srcDpOn), .srcDmOn(srcDmOn),
    .sinkDpOn(sinkDpOn), .sinkDmOn(sinkDmOn), .probeDpOn(probeDpOn), .probeDmOn(probeDmOn),
    .lineVoltSeen(lineVoltSeen), .headsetAudioOn(headsetAudioOn),
    .idMeasureBusy(idMeasureBusy), .idMeasureFinished(idMeasureFinished),
    .idResistanceCode(idResistanceCode), .altInt(altInt), .idConvLatch(idConvLatch));
  cair_link_model link (.ref_clk(ref_clk), .regRdData(regRdData), .regRdValid(regRdValid),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    link.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, e);
  endtask : rchk
  task automatic wait_irq;
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      #1;
      if (altInt === 1'b1) break;
    end
    chk({7'h00, altInt}, 8'h01);
  endtask : wait_irq
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rchk(6'h32, 8'h00);
    rchk(6'h36, 8'h00);
    chk({3'h0, headsetAudioOn, idConvLatch, altInt, idMeasureFinished, srcDpOn}, 8'h00);
    foreach (rows[i]) begin
      link.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].r);
      chk({7'h00, headsetAudioOn}, {7'h00, rows[i].k});
    end
    @(posedge ref_clk) dpVoltRaw <= 1'b1;
    link.wr(6'h32, 8'h03);
    rchk(6'h32, 8'h13);
    chk({4'h0, srcDpOn, srcDmOn, sinkDpOn, sinkDmOn}, 8'h0A);
    @(posedge ref_clk) lineState <= 2'h1;
    rchk(6'h32, 8'h03);
    @(posedge ref_clk) lineState <= 2'h0;
    link.wr(6'h32, 8'h0D);
    rchk(6'h32, 8'h0D);
    chk({4'h0, srcDpOn, srcDmOn, probeDpOn, probeDmOn}, 8'h05);
    @(posedge ref_clk) dpVoltRaw <= 1'b0;
    dmVoltRaw <= 1'b1;
    link.wr(6'h32, 8'h0A);
    rchk(6'h32, 8'h1A);
    chk({5'h00, lineVoltSeen, sinkDpOn, sinkDmOn}, 8'h05);
    link.wr(6'h32, 8'h00);
    @(posedge ref_clk) idCodeIn <= 3'h5;
    link.wr(6'h36, 8'h40);
    link.wr(6'h37, 8'h10);
    rchk(6'h36, 8'h50);
    wait_irq();
    @(posedge ref_clk);
    #1;
    chk({3'h0, idMeasureFinished, idConvLatch, idResistanceCode}, 8'h1D);
    rchk(6'h36, 8'h4D);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h00, idMeasureFinished}, 8'h00);
    @(posedge ref_clk) carkitLatchRead <= 1'b1;
    @(posedge ref_clk) carkitLatchRead <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({7'h00, idConvLatch}, 8'h00);
    link.wr(6'h38, 8'h40);
    @(posedge ref_clk) carkitIrqEn <= 1'b1;
    idCodeIn <= 3'h7;
    link.wr(6'h37, 8'h10);
    wait_irq();
    @(posedge ref_clk) carkitLatchRead <= 1'b1;
    @(posedge ref_clk) carkitLatchRead <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({3'h0, idMeasureFinished, idConvLatch, idResistanceCode}, 8'h17);
    // A reset after the second conversion must bring the key, the done flag and the code back to zero.
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rchk(6'h33, 8'h00);
    rchk(6'h36, 8'h00);
    chk({3'h0, headsetAudioOn, idConvLatch, altInt, idMeasureFinished, idMeasureBusy}, 8'h00);
    give_verdict();
  end
endmodule : testbench
